// file: iq_corr_pkg.sv
package iq_corr_pkg;
	// register map, byte-wide registers on the serial port
	localparam logic [6:0] ADDR_PHASE_LO = 7'h35;
	localparam logic [6:0] ADDR_PHASE_HI = 7'h36;
	localparam logic [6:0] ADDR_SKEW_LO = 7'h37;
	localparam logic [6:0] ADDR_SKEW_HI = 7'h38;
	localparam logic [6:0] ADDR_LANE_PD = 7'h39;
	localparam logic [6:0] ADDR_IOFF_LO = 7'h3B;
	localparam logic [6:0] ADDR_IOFF_HI = 7'h3C;
	localparam logic [6:0] ADDR_QOFF_LO = 7'h3D;
	localparam logic [6:0] ADDR_QOFF_HI = 7'h3E;
	localparam logic [6:0] ADDR_IGAIN = 7'h3F;
	localparam logic [6:0] ADDR_QGAIN = 7'h40;
	// reset values and field widths
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [5:0] GAIN_RESET = 6'h20;
	localparam int GAIN_W = 6;
	localparam int GAIN_FRAC = 5;
	localparam int SKEW_W = 13;
	localparam int SKEW_HI_W = 5;
	localparam int SKEW_FRAC = 14;
	localparam int LANE_W = 4;
	// weights in micro-degrees per code step
	localparam int PHASE_STEP_UDEG = 5500;
	localparam int SKEW_STEP_UDEG = 3500;
	// serial frame: one direction bit, seven address bits, eight data bits
	localparam int RW_BIT = 7;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA, SPI_DONE} spi_state_t;
endpackage

// file: channel_if.sv
`timescale 1ns/100ps
interface channel_if #(parameter int W = 16);
	logic valid;
	logic signed [W-1:0] sample;
	logic signed [W-1:0] skewTerm;
	logic signed [W-1:0] offset;
	logic [iq_corr_pkg::GAIN_W-1:0] gain;
	logic signed [W-1:0] result;
	logic resultValid;
	modport feed (output valid, sample, skewTerm, offset, gain, input result, resultValid);
	modport core (input valid, sample, skewTerm, offset, gain, output result, resultValid);
endinterface

// file: iq_channel.sv
`timescale 1ns/100ps
module iq_channel #(parameter int W = 16) (
	input wire logic ref_clk,
	input wire logic reset_n,
	channel_if.core ch
);
	localparam int MAXV = 2 ** (W - 1) - 1;
	localparam int MINV = -(2 ** (W - 1));

	if (W < 8 || W > 24) begin : gWidthCheck
		$error("iq_channel: sample width out of range");
	end

	logic signed [W+6:0] prod;
	logic signed [W+6:0] scaled;
	logic signed [W+7:0] sum;
	logic signed [W-1:0] next_result;
	logic next_resultValid;

	////////////////////////////////////////////////////////////////////////
	// gain, then cross term and offset, then clamp to the sample range
	always_comb begin
		prod = ch.sample * $signed({1'b0, ch.gain});
		scaled = prod >>> iq_corr_pkg::GAIN_FRAC; // code 0x20 is exactly unity
		sum = (W+8)'(scaled) + (W+8)'(ch.skewTerm) + (W+8)'(ch.offset);
		next_resultValid = ch.valid;
		next_result = ch.result;
		if (ch.valid) begin
			// clamp rather than wrap, a wrapped sample is a full-scale glitch
			if (sum > MAXV) begin
				next_result = MAXV[W-1:0];
			end else if (sum < MINV) begin
				next_result = MINV[W-1:0];
			end else begin
				next_result = sum[W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ch.result <= '0;
			ch.resultValid <= 1'b0;
		end else begin
			ch.result <= next_result;
			ch.resultValid <= next_resultValid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_SAT_HIGH: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ch.valid && sum > MAXV |=> ch.result == MAXV[W-1:0])
		else $error("positive overflow not clamped");
	AST_SAT_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ch.valid && sum < MINV |=> ch.result == MINV[W-1:0])
		else $error("negative overflow not clamped");
	AST_OFFSET_ADD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ch.valid && ch.gain == iq_corr_pkg::GAIN_RESET && ch.skewTerm == '0
		&& sum <= MAXV && sum >= MINV
		|=> ch.result == W'($past(ch.sample) + $past(ch.offset)))
		else $error("offset not added to sample at unity gain");
	AST_ZERO_GAIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ch.valid && ch.gain == '0 && ch.skewTerm == '0 |=> ch.result == $past(ch.offset))
		else $error("zero gain does not remove the sample");
	AST_VALID_FOLLOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ch.resultValid == $past(ch.valid))
		else $error("result strobe does not follow input strobe");
endmodule

// file: iq_correction_datapath.sv
// Behaviour
// - phase offset halves form 16-bit start phase, loaded into oscillator at reset.
// - one phase code step is 0.0055 degrees, full range one carrier cycle.
// - 13-bit signed skew from eight low and five high bits sets I/Q phase.
// - skew covers about plus/minus 14 degrees at 0.0035 degrees per step.
// - four separate power-down bits, one per data input lane zero to three.
// - two bytes form 16-bit I offset added to every I sample.
// - two bytes form 16-bit Q offset added to every Q sample.
// - I gain is 6-bit unsigned, one integer and five fraction bits.
// - I gain resets to 0x20, treated as exact unity.
// - Q gain has own 6-bit multiplier, same weighting, resets to unity.
`timescale 1ns/100ps
module iq_correction_datapath #(parameter int SAMPLE_W = 16) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic chipSelect_n,
	input wire logic sdioIn,
	output logic sdioOut,
	output logic sdioEnable_n,
	input wire logic dataValid,
	input wire logic signed [SAMPLE_W-1:0] iData,
	input wire logic signed [SAMPLE_W-1:0] qData,
	output logic outValid,
	output logic signed [SAMPLE_W-1:0] iOut,
	output logic signed [SAMPLE_W-1:0] qOut,
	output logic [iq_corr_pkg::LANE_W-1:0] laneOff,
	output logic [15:0] carrierStartPhase,
	output logic carrierPhaseLoad
);
	if (SAMPLE_W != 16) begin : gWidthCheck
		$error("offset registers serve 16-bit samples only");
	end

	// serial synchronisers; stage 1 feeds stage 2 only
	logic sclkS1, sclkS2, sclkS3, csS1, csS2, sdiS1, sdiS2;
	iq_corr_pkg::spi_state_t state, next_state;
	logic [2:0] bitCount, next_bitCount;
	logic [7:0] shift, next_shift;
	logic isRead, next_isRead;
	logic [6:0] addr, next_addr;
	logic next_sdioOut, next_sdioEnable_n;
	logic wrEn;
	logic [7:0] wrData;
	logic sclkRise, sclkFall;

	// configuration registers
	logic [7:0] phaseLo, phaseHi, skewLo, iOffLo, iOffHi, qOffLo, qOffHi;
	logic [iq_corr_pkg::SKEW_HI_W-1:0] skewHi;
	logic [iq_corr_pkg::GAIN_W-1:0] iGain, qGain;
	logic [7:0] next_phaseLo, next_phaseHi, next_skewLo, next_iOffLo, next_iOffHi;
	logic [7:0] next_qOffLo, next_qOffHi;
	logic [iq_corr_pkg::SKEW_HI_W-1:0] next_skewHi;
	logic [iq_corr_pkg::GAIN_W-1:0] next_iGain, next_qGain;
	logic [iq_corr_pkg::LANE_W-1:0] next_laneOff;
	logic [15:0] next_carrierStartPhase;

	// datapath stage one
	logic signed [SAMPLE_W-1:0] iS1, qS1, next_iS1, next_qS1;
	logic valid1, next_valid1;
	logic signed [iq_corr_pkg::SKEW_W-1:0] skew;
	logic signed [SAMPLE_W+iq_corr_pkg::SKEW_W-1:0] crossProd;
	logic signed [SAMPLE_W-1:0] qCross;

	// readback mux; unused upper bits and unmapped addresses read zero
	function automatic logic [7:0] readReg(input logic [6:0] a);
		case (a)
			iq_corr_pkg::ADDR_PHASE_LO: readReg = phaseLo;
			iq_corr_pkg::ADDR_PHASE_HI: readReg = phaseHi;
			iq_corr_pkg::ADDR_SKEW_LO: readReg = skewLo;
			iq_corr_pkg::ADDR_SKEW_HI: readReg = {3'h0, skewHi};
			iq_corr_pkg::ADDR_LANE_PD: readReg = {4'h0, laneOff};
			iq_corr_pkg::ADDR_IOFF_LO: readReg = iOffLo;
			iq_corr_pkg::ADDR_IOFF_HI: readReg = iOffHi;
			iq_corr_pkg::ADDR_QOFF_LO: readReg = qOffLo;
			iq_corr_pkg::ADDR_QOFF_HI: readReg = qOffHi;
			iq_corr_pkg::ADDR_IGAIN: readReg = {2'h0, iGain};
			iq_corr_pkg::ADDR_QGAIN: readReg = {2'h0, qGain};
			default: readReg = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge ref_clk) begin
		sclkS1 <= sclk;
		sclkS2 <= sclkS1;
		sclkS3 <= sclkS2;
		csS1 <= chipSelect_n;
		csS2 <= csS1;
		sdiS1 <= sdioIn;
		sdiS2 <= sdiS1;
	end

	assign sclkRise = sclkS2 && !sclkS3;
	assign sclkFall = !sclkS2 && sclkS3;

	////////////////////////////////////////////////////////////////////////
	// serial slave: 8-bit command, then 8 data bits, msb first
	always_comb begin
		next_state = state;
		next_bitCount = bitCount;
		next_shift = shift;
		next_isRead = isRead;
		next_addr = addr;
		next_sdioOut = sdioOut;
		next_sdioEnable_n = sdioEnable_n;
		wrEn = 1'b0;
		wrData = {shift[6:0], sdiS2};
		if (csS2) begin
			// deselect aborts any frame and frees the shared pin
			next_state = iq_corr_pkg::SPI_IDLE;
			next_sdioEnable_n = 1'b1;
		end else begin
			case (state)
				iq_corr_pkg::SPI_IDLE: begin
					next_state = iq_corr_pkg::SPI_CMD;
					next_bitCount = '0;
				end
				iq_corr_pkg::SPI_CMD: begin
					if (sclkRise) begin
						next_shift = {shift[6:0], sdiS2};
						next_bitCount = bitCount + 3'h1;
						if (bitCount == iq_corr_pkg::LAST_BIT) begin
							next_isRead = shift[iq_corr_pkg::RW_BIT-1];
							next_addr = {shift[5:0], sdiS2};
							next_state = iq_corr_pkg::SPI_DATA;
							if (shift[iq_corr_pkg::RW_BIT-1]) begin
								next_shift = readReg({shift[5:0], sdiS2});
							end
						end
					end
				end
				iq_corr_pkg::SPI_DATA: begin
					if (isRead && sclkFall) begin
						next_sdioOut = shift[7];
						next_sdioEnable_n = 1'b0;
						next_shift = {shift[6:0], 1'b0};
					end
					if (sclkRise) begin
						next_bitCount = bitCount + 3'h1;
						if (!isRead) begin
							next_shift = {shift[6:0], sdiS2};
						end
						if (bitCount == iq_corr_pkg::LAST_BIT) begin
							wrEn = !isRead;
							next_state = iq_corr_pkg::SPI_DONE;
						end
					end
				end
				iq_corr_pkg::SPI_DONE: begin
					if (sclkFall) begin
						next_sdioEnable_n = 1'b1;
					end
				end
				default: next_state = iq_corr_pkg::SPI_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state <= iq_corr_pkg::SPI_IDLE;
			bitCount <= '0;
			shift <= '0;
			isRead <= 1'b0;
			addr <= '0;
			sdioOut <= 1'b0;
			sdioEnable_n <= 1'b1;
		end else begin
			state <= next_state;
			bitCount <= next_bitCount;
			shift <= next_shift;
			isRead <= next_isRead;
			addr <= next_addr;
			sdioOut <= next_sdioOut;
			sdioEnable_n <= next_sdioEnable_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes; unmapped addresses are ignored
	always_comb begin
		next_phaseLo = phaseLo;
		next_phaseHi = phaseHi;
		next_skewLo = skewLo;
		next_skewHi = skewHi;
		next_laneOff = laneOff;
		next_iOffLo = iOffLo;
		next_iOffHi = iOffHi;
		next_qOffLo = qOffLo;
		next_qOffHi = qOffHi;
		next_iGain = iGain;
		next_qGain = qGain;
		if (wrEn) begin
			case (addr)
				iq_corr_pkg::ADDR_PHASE_LO: next_phaseLo = wrData;
				iq_corr_pkg::ADDR_PHASE_HI: next_phaseHi = wrData;
				iq_corr_pkg::ADDR_SKEW_LO: next_skewLo = wrData;
				iq_corr_pkg::ADDR_SKEW_HI: next_skewHi = wrData[iq_corr_pkg::SKEW_HI_W-1:0];
				iq_corr_pkg::ADDR_LANE_PD: next_laneOff = wrData[iq_corr_pkg::LANE_W-1:0];
				iq_corr_pkg::ADDR_IOFF_LO: next_iOffLo = wrData;
				iq_corr_pkg::ADDR_IOFF_HI: next_iOffHi = wrData;
				iq_corr_pkg::ADDR_QOFF_LO: next_qOffLo = wrData;
				iq_corr_pkg::ADDR_QOFF_HI: next_qOffHi = wrData;
				iq_corr_pkg::ADDR_IGAIN: next_iGain = wrData[iq_corr_pkg::GAIN_W-1:0];
				iq_corr_pkg::ADDR_QGAIN: next_qGain = wrData[iq_corr_pkg::GAIN_W-1:0];
				default: next_iGain = iGain;
			endcase
		end
		// twos-complement code, 0.0055 deg per step
		next_carrierStartPhase = {phaseHi, phaseLo};
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phaseLo <= iq_corr_pkg::BYTE_RESET;
			phaseHi <= iq_corr_pkg::BYTE_RESET;
			skewLo <= iq_corr_pkg::BYTE_RESET;
			skewHi <= '0;
			laneOff <= '0;
			iOffLo <= iq_corr_pkg::BYTE_RESET;
			iOffHi <= iq_corr_pkg::BYTE_RESET;
			qOffLo <= iq_corr_pkg::BYTE_RESET;
			qOffHi <= iq_corr_pkg::BYTE_RESET;
			iGain <= iq_corr_pkg::GAIN_RESET;
			qGain <= iq_corr_pkg::GAIN_RESET;
			carrierStartPhase <= '0;
			carrierPhaseLoad <= 1'b1; // oscillator takes start phase during reset
		end else begin
			phaseLo <= next_phaseLo;
			phaseHi <= next_phaseHi;
			skewLo <= next_skewLo;
			skewHi <= next_skewHi;
			laneOff <= next_laneOff;
			iOffLo <= next_iOffLo;
			iOffHi <= next_iOffHi;
			qOffLo <= next_qOffLo;
			qOffHi <= next_qOffHi;
			iGain <= next_iGain;
			qGain <= next_qGain;
			carrierStartPhase <= next_carrierStartPhase;
			carrierPhaseLoad <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input stage: powered-down lanes read as zero on both paths
	always_comb begin
		next_valid1 = dataValid;
		next_iS1 = iData & ~SAMPLE_W'(laneOff);
		next_qS1 = qData & ~SAMPLE_W'(laneOff);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			valid1 <= 1'b0;
			iS1 <= '0;
			qS1 <= '0;
		end else begin
			valid1 <= next_valid1;
			iS1 <= next_iS1;
			qS1 <= next_qS1;
		end
	end

	// small-angle skew: Q gains a share of I; 2^-14 rad is near 0.0035 deg,
	// so 4095 steps reach about 14 deg, where the approximation still holds
	assign skew = {skewHi, skewLo};
	assign crossProd = iS1 * skew;
	assign qCross = SAMPLE_W'(crossProd >>> iq_corr_pkg::SKEW_FRAC);

	channel_if #(.W(SAMPLE_W)) iCh();
	channel_if #(.W(SAMPLE_W)) qCh();

	assign iCh.valid = valid1;
	assign iCh.sample = iS1;
	assign iCh.skewTerm = '0;
	assign iCh.offset = {iOffHi, iOffLo};
	assign iCh.gain = iGain;
	assign qCh.valid = valid1;
	assign qCh.sample = qS1;
	assign qCh.skewTerm = qCross;
	assign qCh.offset = {qOffHi, qOffLo};
	assign qCh.gain = qGain;

	iq_channel #(.W(SAMPLE_W)) uChanI (.ref_clk(ref_clk), .reset_n(reset_n), .ch(iCh));
	iq_channel #(.W(SAMPLE_W)) uChanQ (.ref_clk(ref_clk), .reset_n(reset_n), .ch(qCh));

	assign iOut = iCh.result;
	assign qOut = qCh.result;
	assign outValid = iCh.resultValid;

	////////////////////////////////////////////////////////////////////////
	AST_PHASE_LOAD: assert property (@(posedge ref_clk)
		!reset_n ##1 reset_n |-> carrierPhaseLoad ##1 !carrierPhaseLoad)
		else $error("start phase load not pulsed at reset");
	AST_PHASE_VALUE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!carrierPhaseLoad |-> carrierStartPhase == $past({phaseHi, phaseLo}))
		else $error("start phase not built from both bytes");
	AST_I_GAIN_RESET: assert property (@(posedge ref_clk)
		!reset_n |=> iGain == iq_corr_pkg::GAIN_RESET)
		else $error("I gain not unity after reset");
	AST_Q_GAIN_RESET: assert property (@(posedge ref_clk)
		!reset_n |=> qGain == iq_corr_pkg::GAIN_RESET)
		else $error("Q gain not unity after reset");
	AST_SKEW_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		wrEn && addr == iq_corr_pkg::ADDR_SKEW_HI
		|=> skew[iq_corr_pkg::SKEW_W-1 -: iq_corr_pkg::SKEW_HI_W]
		== $past(wrData[iq_corr_pkg::SKEW_HI_W-1:0]))
		else $error("skew upper bits not taken from write");
	AST_SKEW_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		skew == '0 |-> qCross == '0)
		else $error("zero skew still disturbs Q path");
	AST_LANE_MASK: assert property (@(posedge ref_clk) disable iff (!reset_n)
		dataValid |=> (iS1 & SAMPLE_W'($past(laneOff))) == '0
		&& (qS1 & SAMPLE_W'($past(laneOff))) == '0)
		else $error("powered-down lane still carries data");
	AST_LATENCY: assert property (@(posedge ref_clk) disable iff (!reset_n)
		dataValid |-> ##2 outValid)
		else $error("corrected sample not out two cycles after input");
endmodule

// file: sample_host.sv
`timescale 1ns/100ps
// host logic on the parallel sample input, fed from a list of pairs
module sample_host (
	input wire logic ref_clk,
	output logic dataValid,
	output logic signed [15:0] iData,
	output logic signed [15:0] qData
);
	logic [31:0] pending [$];

	task automatic push(input logic [31:0] pair);
		pending.push_back(pair);
	endtask

	////////////////////////////////////////////////////////////////////////
	// one pair a cycle while any wait; between strobes the lines flip
	// so a design that samples without the strobe sees garbage
	always @(posedge ref_clk) begin
		if (pending.size() > 0) begin
			{iData, qData} <= pending.pop_front();
			dataValid <= 1'b1;
		end else begin
			dataValid <= 1'b0;
			iData <= ~iData;
			qData <= ~qData;
		end
	end
endmodule

// file: iq_correction_datapath_bench.sv
`timescale 1ns/100ps
`define CHECK(w, e, g) begin \
	checksDone++; \
	if ((e) !== (g)) begin \
		failures++; \
		$display("unexpected %s: expected %h, seen %h", w, e, g); \
	end \
end
module iq_correction_datapath_bench;
	logic ref_clk, reset_n, sclk, chipSelect_n, sdioBit, sdioIn, sdioOut, sdioEnable_n;
	logic dataValid, outValid, carrierPhaseLoad;
	logic signed [15:0] iData, qData, iOut, qOut;
	logic [3:0] laneOff;
	logic [15:0] carrierStartPhase;
	logic [7:0] regs [0:127];
	logic [31:0] expq [$];
	logic [31:0] note;
	logic [7:0] rd;
	logic [6:0] probe [13] = '{7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3B, 7'h3C,
		7'h3D, 7'h3E, 7'h3F, 7'h40, 7'h3A, 7'h7F};
	int failures = 0;
	int checksDone = 0;
	int k;

	// device owns the wire once its enable is low
	assign sdioIn = (sdioEnable_n === 1'b0) ? sdioOut : sdioBit;

	iq_correction_datapath uut (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
		.chipSelect_n(chipSelect_n), .sdioIn(sdioIn), .sdioOut(sdioOut),
		.sdioEnable_n(sdioEnable_n), .dataValid(dataValid), .iData(iData), .qData(qData),
		.outValid(outValid), .iOut(iOut), .qOut(qOut), .laneOff(laneOff),
		.carrierStartPhase(carrierStartPhase), .carrierPhaseLoad(carrierPhaseLoad));
	sample_host host (.ref_clk(ref_clk), .dataValid(dataValid), .iData(iData), .qData(qData));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// reference arithmetic, kept in wide integers so clamping is visible
	function automatic logic [15:0] sat(input longint v);
		if (v > 32767) return 16'h7FFF;
		if (v < -32768) return 16'h8000;
		return v[15:0];
	endfunction

	function automatic logic [31:0] expect_pair(input logic signed [15:0] i,
		input logic signed [15:0] q);
		logic signed [15:0] mi, mq, io, qo;
		logic signed [12:0] sk;
		longint im, qm, iv, qv;
		mi = i & ~{12'h000, regs[7'h39][3:0]};
		mq = q & ~{12'h000, regs[7'h39][3:0]};
		io = {regs[7'h3C], regs[7'h3B]};
		qo = {regs[7'h3E], regs[7'h3D]};
		sk = {regs[7'h38][4:0], regs[7'h37]};
		im = mi;
		qm = mq;
		iv = ((im * longint'(regs[7'h3F][5:0])) >>> 5) + io;
		qv = ((qm * longint'(regs[7'h40][5:0])) >>> 5) + ((im * sk) >>> 14) + qo;
		return {sat(iv), sat(qv)};
	endfunction

	// readback: unused upper bits and unmapped places read zero
	function automatic logic [7:0] rb(input logic [6:0] a);
		case (a)
			7'h38: return regs[a] & 8'h1F;
			7'h39: return regs[a] & 8'h0F;
			7'h3F, 7'h40: return regs[a] & 8'h3F;
			7'h35, 7'h36, 7'h37, 7'h3B, 7'h3C, 7'h3D, 7'h3E: return regs[a];
			default: return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic do_reset(input int n);
		int a;
		@(posedge ref_clk) reset_n <= 1'b0;
		repeat (n) @(posedge ref_clk);
		`CHECK("carrierPhaseLoad", 1'b1, carrierPhaseLoad)
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHECK("carrierPhaseLoad", 1'b0, carrierPhaseLoad)
		for (a = 0; a < 128; a++) regs[a] = 8'h00;
		regs[7'h3F] = 8'h20;
		regs[7'h40] = 8'h20;
	endtask

	// one frame; sclk high for six cycles and low for seven keeps the synchroniser happy
	task automatic spi(input logic r, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [15:0] frame;
		int b;
		frame = {r, a, d};
		q = 8'h00;
		@(posedge ref_clk) chipSelect_n <= 1'b0;
		for (b = 15; b >= 0; b--) begin
			@(posedge ref_clk) sdioBit <= (r && b < 8) ? ~sdioIn : frame[b];
			repeat (6) @(posedge ref_clk);
			if (r && b < 8) q[b] = sdioIn;
			sclk <= 1'b1;
			repeat (6) @(posedge ref_clk);
			sclk <= 1'b0;
		end
		repeat (6) @(posedge ref_clk);
		chipSelect_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		spi(1'b0, a, d, rd);
		regs[a] = d;
	endtask

	task automatic readall();
		int j;
		for (j = 0; j < 13; j++) begin
			spi(1'b1, probe[j], 8'h00, rd);
			`CHECK("readback", rb(probe[j]), rd)
		end
	endtask

	task automatic send(input logic [15:0] i, input logic [15:0] q);
		expq.push_back(expect_pair(i, q));
		host.push({i, q});
	endtask

	task automatic drain();
		int n;
		for (n = 0; n < 100 && expq.size() > 0; n++) @(posedge ref_clk);
		if (expq.size() > 0) begin
			failures++;
			$display("unexpected drain: expected 0, seen %0d", expq.size());
			report_and_stop();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// result watcher: every strobe out must match the oldest note
	always @(posedge ref_clk) begin
		if (outValid === 1'b1) begin
			if (expq.size() == 0) begin
				`CHECK("outValid", 1'b0, outValid)
			end else begin
				note = expq.pop_front();
				`CHECK("iOut", note[31:16], iOut)
				`CHECK("qOut", note[15:0], qOut)
			end
		end
	end

	// hang guard, far above the length of the main sequence
	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		$display("unexpected timeout: expected end, seen hang");
		report_and_stop();
	end

	initial begin
		reset_n = 1'b0;
		sclk = 1'b0;
		chipSelect_n = 1'b1;
		sdioBit = 1'b0;
		void'($urandom(60548));
		do_reset(16);
		readall();
		`CHECK("laneOff", 4'h0, laneOff)
		`CHECK("carrierStartPhase", 16'h0000, carrierStartPhase)
		repeat (8) send(16'($urandom), 16'($urandom));
		drain();
		$display("test reset_and_unity done");
		// random settings of every place, then a back-to-back stream
		repeat (3) begin
			for (k = 0; k < 13; k++) wr(probe[k], 8'($urandom));
			readall();
			`CHECK("laneOff", regs[7'h39][3:0], laneOff)
			`CHECK("carrierStartPhase", {regs[7'h36], regs[7'h35]}, carrierStartPhase)
			repeat (24) send(16'($urandom), 16'($urandom));
			drain();
		end
		$display("test random_settings done");
		// one lane at a time, unity gain so masking shows
		wr(7'h3F, 8'h20);
		wr(7'h40, 8'h20);
		for (k = 0; k < 4; k++) begin
			wr(7'h39, 8'h01 << k);
			`CHECK("laneOff", 4'h1 << k, laneOff)
			send(16'hFFFF, 16'h000F);
			drain();
		end
		$display("test lanes done");
		// extremes against full gain and large offsets
		wr(7'h39, 8'h00);
		wr(7'h3B, 8'hFF);
		wr(7'h3C, 8'h7F);
		wr(7'h3E, 8'h80);
		wr(7'h3F, 8'h3F);
		wr(7'h40, 8'h3F);
		send(16'h7FFF, 16'h8000);
		send(16'h8000, 16'h7FFF);
		send(16'h7FFF, 16'h7FFF);
		drain();
		$display("test saturation done");
		// zero gain leaves only the offset on the I path
		wr(7'h3F, 8'h00);
		send(16'h1234, 16'h4321);
		drain();
		$display("test zero_gain done");
		// reset in mid-run brings the settings back
		wr(7'h36, 8'($urandom));
		do_reset(4);
		readall();
		`CHECK("carrierStartPhase", 16'h0000, carrierStartPhase)
		$display("test second_reset done");
		report_and_stop();
	end
endmodule
